/* File: hdl/ubsr_pkg.sv */
/*
 * Shared constants and types of the upper special register bank: register
 * indices, field positions, reset values, the table of plain storage
 * registers, the bus state encoding and the packed state records.
 * Assumes a SystemVerilog-2012 tool; nothing here holds logic.
 */
package ubsr_pkg;

	// Bus geometry: each register index is one aligned 32-bit word
	localparam int AXI_AW = 12;
	localparam int AXI_DW = 32;
	localparam int IDX_W  = 8;
	localparam int REG_W  = 8;
	localparam int PC_W   = 13;
	localparam int LAT_W  = 5;
	localparam int DM_AW  = 9;
	localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
	localparam logic [1:0] WORD_ALIGN    = 2'h0;

	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_INDIRECT_ACCESS_PORT = 8'h80;
	localparam logic [7:0] IDX_COUNTER_LOW_BYTE     = 8'h82;
	localparam logic [7:0] IDX_CORE_FLAGS           = 8'h83;
	localparam logic [7:0] IDX_INDIRECT_POINTER     = 8'h84;
	localparam logic [7:0] IDX_PORT_E_DIR_SLAVE     = 8'h89;
	localparam logic [7:0] IDX_COUNTER_UPPER_LATCH  = 8'h8A;
	localparam logic [7:0] IDX_INTERRUPT_CONTROL    = 8'h8B;
	localparam logic [7:0] IDX_POWER_RESET_CAUSE    = 8'h8E;
	localparam logic [7:0] IDX_SYNC_SERIAL_STATE    = 8'h94;
	localparam logic [7:0] IDX_ASYNC_TX_CONTROL     = 8'h98;
	localparam logic [7:0] IDX_BANK_FIRST           = 8'h80;
	localparam logic [7:0] IDX_BANK_LAST            = 8'h9F;
	localparam int         BANK_SEL_BIT             = 7;

	// Core flag fields
	localparam int FLG_INDIRECT_BANK_SELECT = 7;
	localparam int FLG_TIMEOUT              = 4;
	localparam int FLG_POWERDOWN            = 3;
	localparam logic [7:0] FLG_WMASK        = 8'hE7;
	localparam logic [7:0] FLG_POWER_RST    = 8'h18;
	localparam logic [7:0] FLG_KEEP_WARM    = 8'h07;

	// Interrupt control: lowest bit survives a warm reset
	localparam logic [7:0] INTC_KEEP_WARM = 8'h01;

	// Fifth port direction and slave port status
	localparam int SLV_FLAGS_LSB = 6;
	localparam int SLV_OVERFLOW  = 5;
	localparam logic [7:0] PE_WMASK  = 8'h37;
	localparam logic [7:0] PE_RST    = 8'h07;

	// Async transmit control
	localparam int TX_SHIFT_IDLE = 1;
	localparam logic [7:0] TX_WMASK = 8'hF5;
	localparam logic [7:0] TX_RST   = 8'h02;

	// Power reset cause bit positions
	localparam int PWR_POWERON  = 1;
	localparam int PWR_BROWNOUT = 0;

	// Plain storage registers: same value on every kind of reset
	localparam int NUM_PLAIN    = 11;
	localparam int PLAIN_PORT_D = 4;
	localparam logic [NUM_PLAIN-1:0][7:0] PLAIN_IDX = {
		8'h9F, 8'h99, 8'h93, 8'h92, 8'h8D, 8'h8C,
		8'h88, 8'h87, 8'h86, 8'h85, 8'h81};
	localparam logic [NUM_PLAIN-1:0][7:0] PLAIN_RST = {
		8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
		8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF};
	localparam logic [NUM_PLAIN-1:0][7:0] PLAIN_MASK = {
		8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF};

	// Bus sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_WACC  = 7'h02,
		ST_WRESP = 7'h04,
		ST_RACC  = 7'h08,
		ST_RMEM  = 7'h10,
		ST_RWAIT = 7'h20,
		ST_RRESP = 7'h40
	} ubsr_state_t;

	typedef struct packed {
		logic [7:0] val;
	} ubsr_cell_t;

	typedef struct packed {
		ubsr_state_t       state;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic              arready;
		logic              rvalid;
		logic [7:0]        rdata;
		logic [PC_W-1:0]   pc;
		logic [LAT_W-1:0]  upper_latch;
		logic [7:0]        core_flags;
		logic [7:0]        pointer;
		logic [7:0]        int_ctrl;
		logic              poweron_flag;
		logic              brownout_flag;
		logic [7:0]        port_e_dir;
		logic [7:0]        tx_ctrl;
		logic [5:0]        serial_state;
		logic [DM_AW-1:0]  dm_addr;
		logic              dm_we;
		logic              dm_re;
		logic [7:0]        dm_wdata;
	} ubsr_core_t;

endpackage : ubsr_pkg

/* File: hdl/ubsr_plain_reg.sv */
/*
 * One plain storage register of the bank: loads its reset value on a
 * power-up or warm reset, takes masked write data on a write strobe.
 * Assumes the strobe and the resets come from logic on the same clock.
 */
module ubsr_plain_reg
	import ubsr_pkg::*;
#(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] MASK    = 8'hFF,
	parameter bit         ENABLE  = 1'b1
) (
	input  wire logic       clk_i,
	input  wire logic       ce_i,
	input  wire logic       power_rst_i,
	input  wire logic       warm_rst_i,
	input  wire logic       we_i,
	input  wire logic [7:0] wdata_i,
	output logic [7:0]      q_o
);

	ubsr_cell_t cell_ff;
	ubsr_cell_t nxt_cell;

	// Absent register stays zero, so reads of it return zero
	always_comb begin
		nxt_cell = cell_ff;
		if (power_rst_i || warm_rst_i) begin
			nxt_cell.val = RST_VAL & MASK;
		end else if (we_i) begin
			nxt_cell.val = wdata_i & MASK; // Unused bits dropped
		end
		if (!ENABLE) begin
			nxt_cell.val = 8'h00;
		end
	end

	// Frozen while the clock enable is low
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			cell_ff <= nxt_cell;
		end
	end

	assign q_o = cell_ff.val;

endmodule : ubsr_plain_reg

/* File: hdl/ubsr_bank.sv */
/*
 * Upper special register bank: AXI4-Lite slave holding the bank's
 * registers, the mirrored core registers, the program counter with its
 * upper latch, and the indirect path to data memory.
 * Assumes single-beat AXI4-Lite masters, a data memory answering one
 * cycle after its read strobe, and reset causes from same-clock logic.
 */
// The AXI4-Lite slave port was chosen for this implementation.
// Behaviour
// - Empty locations and unused bits read zero, ignore writes
// - Counter upper bits only loaded through latch
// - Core registers decoded alike in both banks
// - Warm resets and power resets load their values
// - Absent fourth/fifth port registers read zero
// - Brownout bit reads zero without brownout detection
module ubsr_bank
	import ubsr_pkg::*;
#(
	parameter bit HAS_FOURTH_FIFTH_PORTS = 1'b1,
	parameter bit HAS_BROWNOUT_DETECT    = 1'b1
) (
	input  wire logic                          CLOCK_I,
	input  wire logic                          SRST_I,
	input  wire logic                          CE_I,
	input  wire logic                          BROWNOUT_I,
	input  wire logic                          WARM_RST_I,
	input  wire logic                          WARM_WDT_I,
	input  wire logic                          PC_STEP_I,
	input  wire logic [1:0]                    SLAVE_FLAGS_I,
	input  wire logic                          SLAVE_OVF_I,
	input  wire logic [5:0]                    SSP_STATE_I,
	input  wire logic                          TX_IDLE_I,
	input  wire logic [ubsr_pkg::REG_W-1:0]    DMEM_RDATA_I,
	input  wire logic [ubsr_pkg::AXI_AW-1:0]   S_AXI_AWADDR_I,
	input  wire logic                          S_AXI_AWVALID_I,
	input  wire logic [ubsr_pkg::AXI_DW-1:0]   S_AXI_WDATA_I,
	input  wire logic [3:0]                    S_AXI_WSTRB_I,
	input  wire logic                          S_AXI_WVALID_I,
	input  wire logic                          S_AXI_BREADY_I,
	input  wire logic [ubsr_pkg::AXI_AW-1:0]   S_AXI_ARADDR_I,
	input  wire logic                          S_AXI_ARVALID_I,
	input  wire logic                          S_AXI_RREADY_I,
	output logic                               S_AXI_AWREADY_O,
	output logic                               S_AXI_WREADY_O,
	output logic                               S_AXI_BVALID_O,
	output logic [1:0]                         S_AXI_BRESP_O,
	output logic                               S_AXI_ARREADY_O,
	output logic                               S_AXI_RVALID_O,
	output logic [ubsr_pkg::AXI_DW-1:0]        S_AXI_RDATA_O,
	output logic [1:0]                         S_AXI_RRESP_O,
	output logic [ubsr_pkg::PC_W-1:0]          PC_O,
	output logic [ubsr_pkg::DM_AW-1:0]         DMEM_ADDR_O,
	output logic                               DMEM_WE_O,
	output logic                               DMEM_RE_O,
	output logic [ubsr_pkg::REG_W-1:0]         DMEM_WDATA_O
);

	import ubsr_pkg::*;

	ubsr_core_t                   core_ff;
	ubsr_core_t                   nxt_core;
	logic [NUM_PLAIN-1:0][7:0]    plain_q;
	logic [NUM_PLAIN-1:0]         plain_we;
	logic [8:0]                   wr_map;
	logic [8:0]                   rd_map;
	logic                         wr_hit;
	logic [7:0]                   wbyte;

	// Address to bank index; top bit of result marks a live location.
	// Bank-zero copies of the core registers fold onto the same index.
	function automatic logic [8:0] map_idx(input logic [AXI_AW-1:0] a);
		logic [7:0] raw;
		logic [7:0] fold;
		raw  = a[IDX_W+1:2];
		fold = raw | IDX_BANK_FIRST;
		map_idx = {1'b0, raw};
		if (a[AXI_AW-1:IDX_W+2] == '0) begin
			if (raw >= IDX_BANK_FIRST && raw <= IDX_BANK_LAST) begin
				map_idx = {1'b1, raw};
			end else if (!raw[BANK_SEL_BIT] &&
			    (fold == IDX_INDIRECT_ACCESS_PORT ||
			     fold == IDX_COUNTER_LOW_BYTE ||
			     fold == IDX_CORE_FLAGS ||
			     fold == IDX_INDIRECT_POINTER ||
			     fold == IDX_COUNTER_UPPER_LATCH ||
			     fold == IDX_INTERRUPT_CONTROL)) begin
				map_idx = {1'b1, fold};
			end
		end
	endfunction : map_idx

	// Read value of a live index; anything not listed reads zero
	function automatic logic [7:0] read_value(
		input logic [7:0]                idx,
		input ubsr_core_t                c,
		input logic [NUM_PLAIN-1:0][7:0] pq
	);
		read_value = 8'h00;
		for (int i = 0; i < NUM_PLAIN; i++) begin
			if (idx == PLAIN_IDX[i]) begin
				read_value = pq[i];
			end
		end
		case (idx)
			IDX_COUNTER_LOW_BYTE:    read_value = c.pc[7:0];
			IDX_CORE_FLAGS:          read_value = c.core_flags;
			IDX_INDIRECT_POINTER:    read_value = c.pointer;
			IDX_COUNTER_UPPER_LATCH: read_value = {3'h0, c.upper_latch};
			IDX_INTERRUPT_CONTROL:   read_value = c.int_ctrl;
			IDX_POWER_RESET_CAUSE: begin
				read_value = 8'h00;
				read_value[PWR_POWERON] = c.poweron_flag;
				read_value[PWR_BROWNOUT] = c.brownout_flag &
				    HAS_BROWNOUT_DETECT;
			end
			IDX_PORT_E_DIR_SLAVE: begin
				read_value = HAS_FOURTH_FIFTH_PORTS ?
				    c.port_e_dir : 8'h00;
			end
			IDX_SYNC_SERIAL_STATE:   read_value = {2'h0, c.serial_state};
			IDX_ASYNC_TX_CONTROL:    read_value = c.tx_ctrl;
			default: begin
			end
		endcase
	endfunction : read_value

	// Write strobe shared by the core registers and the plain cells
	always_comb begin
		wr_map = map_idx(S_AXI_AWADDR_I);
		rd_map = map_idx(S_AXI_ARADDR_I);
		wbyte  = S_AXI_WDATA_I[7:0];
		wr_hit = (core_ff.state == ST_WACC) && S_AXI_AWVALID_I &&
		    S_AXI_WVALID_I && S_AXI_WSTRB_I[0] && wr_map[8];
		for (int i = 0; i < NUM_PLAIN; i++) begin
			plain_we[i] = wr_hit && (wr_map[7:0] == PLAIN_IDX[i]);
		end
	end

	// Plain storage cells; the fourth port's cell is absent on small parts
	for (genvar gi = 0; gi < NUM_PLAIN; gi++) begin : g_plain
		ubsr_plain_reg #(
			.RST_VAL (PLAIN_RST[gi]),
			.MASK    (PLAIN_MASK[gi]),
			.ENABLE  ((gi == PLAIN_PORT_D) ?
			          HAS_FOURTH_FIFTH_PORTS : 1'b1)
		) u_cell (
			.clk_i       (CLOCK_I),
			.ce_i        (CE_I),
			.power_rst_i (SRST_I),
			.warm_rst_i  (WARM_RST_I),
			.we_i        (plain_we[gi]),
			.wdata_i     (wbyte),
			.q_o         (plain_q[gi])
		);
	end

	// Next state: bus sequencer, core register updates, resets last
	always_comb begin
		nxt_core = core_ff;
		nxt_core.dm_we = 1'b0;
		nxt_core.dm_re = 1'b0;
		nxt_core.serial_state = SSP_STATE_I;
		// Counter advance; a write to the low byte below overrides it
		if (PC_STEP_I) begin
			nxt_core.pc = PC_W'(core_ff.pc + 13'h0001);
		end
		case (core_ff.state)
			ST_IDLE: begin
				// Writes first; one transfer at a time keeps order simple
				if (S_AXI_AWVALID_I && S_AXI_WVALID_I) begin
					nxt_core.awready = 1'b1;
					nxt_core.wready = 1'b1;
					nxt_core.state = ST_WACC;
				end else if (S_AXI_ARVALID_I) begin
					nxt_core.arready = 1'b1;
					nxt_core.state = ST_RACC;
				end
			end
			ST_WACC: begin
				nxt_core.awready = 1'b0;
				nxt_core.wready = 1'b0;
				nxt_core.bvalid = 1'b1;
				nxt_core.state = ST_WRESP;
				if (wr_hit) begin
					case (wr_map[7:0])
						IDX_INDIRECT_ACCESS_PORT: begin
							nxt_core.dm_addr = {core_ff.core_flags[
							    FLG_INDIRECT_BANK_SELECT],
							    core_ff.pointer};
							nxt_core.dm_wdata = wbyte;
							nxt_core.dm_we = 1'b1;
						end
						IDX_COUNTER_LOW_BYTE: begin
							nxt_core.pc = {core_ff.upper_latch,
							    wbyte};
						end
						IDX_CORE_FLAGS: begin
							nxt_core.core_flags = (wbyte & FLG_WMASK) |
							    (core_ff.core_flags & ~FLG_WMASK);
						end
						IDX_INDIRECT_POINTER: nxt_core.pointer = wbyte;
						IDX_COUNTER_UPPER_LATCH: begin
							nxt_core.upper_latch = wbyte[LAT_W-1:0];
						end
						IDX_INTERRUPT_CONTROL: nxt_core.int_ctrl = wbyte;
						IDX_POWER_RESET_CAUSE: begin
							nxt_core.poweron_flag = wbyte[PWR_POWERON];
							nxt_core.brownout_flag = wbyte[PWR_BROWNOUT];
						end
						IDX_PORT_E_DIR_SLAVE: begin
							nxt_core.port_e_dir = (wbyte & PE_WMASK) |
							    (core_ff.port_e_dir & ~PE_WMASK);
						end
						IDX_ASYNC_TX_CONTROL: begin
							nxt_core.tx_ctrl = (wbyte & TX_WMASK) |
							    (core_ff.tx_ctrl & ~TX_WMASK);
						end
						default: begin
						end
					endcase
				end
			end
			ST_WRESP: begin
				if (S_AXI_BREADY_I) begin
					nxt_core.bvalid = 1'b0;
					nxt_core.state = ST_IDLE;
				end
			end
			ST_RACC: begin
				nxt_core.arready = 1'b0;
				if (rd_map[8] &&
				    rd_map[7:0] == IDX_INDIRECT_ACCESS_PORT) begin
					// Location stores nothing: fetch from memory
					nxt_core.dm_addr = {core_ff.core_flags[
					    FLG_INDIRECT_BANK_SELECT], core_ff.pointer};
					nxt_core.dm_re = 1'b1;
					nxt_core.state = ST_RMEM;
				end else begin
					nxt_core.rdata = rd_map[8] ?
					    read_value(rd_map[7:0], core_ff, plain_q) :
					    8'h00;
					nxt_core.rvalid = 1'b1;
					nxt_core.state = ST_RRESP;
				end
			end
			ST_RMEM: nxt_core.state = ST_RWAIT;
			ST_RWAIT: begin
				nxt_core.rdata = DMEM_RDATA_I;
				nxt_core.rvalid = 1'b1;
				nxt_core.state = ST_RRESP;
			end
			ST_RRESP: begin
				if (S_AXI_RREADY_I) begin
					nxt_core.rvalid = 1'b0;
					nxt_core.state = ST_IDLE;
				end
			end
			default: begin
				nxt_core.state = ST_IDLE;
			end
		endcase
		// Live status bits follow their sources after any write
		nxt_core.port_e_dir[SLV_FLAGS_LSB+1:SLV_FLAGS_LSB] = SLAVE_FLAGS_I;
		nxt_core.tx_ctrl[TX_SHIFT_IDLE] = TX_IDLE_I;
		// Overflow set beats a same-cycle software clear
		if (SLAVE_OVF_I) begin
			nxt_core.port_e_dir[SLV_OVERFLOW] = 1'b1;
		end
		// Pin or watchdog reset: bus transfer in flight is not disturbed
		if (WARM_RST_I) begin
			nxt_core.pc = '0;
			nxt_core.upper_latch = '0;
			nxt_core.core_flags = core_ff.core_flags & FLG_KEEP_WARM;
			nxt_core.core_flags[FLG_TIMEOUT] = !WARM_WDT_I;
			nxt_core.core_flags[FLG_POWERDOWN] = 1'b1;
			nxt_core.int_ctrl = core_ff.int_ctrl & INTC_KEEP_WARM;
			nxt_core.port_e_dir = PE_RST;
			nxt_core.tx_ctrl = TX_RST;
		end
		// Power-on or brownout: everything to power-up values
		if (SRST_I) begin
			nxt_core = '0;
			nxt_core.state = ST_IDLE;
			nxt_core.core_flags = FLG_POWER_RST;
			nxt_core.port_e_dir = PE_RST;
			nxt_core.tx_ctrl = TX_RST;
			nxt_core.poweron_flag = BROWNOUT_I;
			nxt_core.brownout_flag = !BROWNOUT_I;
		end
	end

	// Single state register; frozen while the clock enable is low
	always_ff @(posedge CLOCK_I) begin
		if (CE_I) begin
			core_ff <= nxt_core;
		end
	end

	// Outputs straight from the state register
	assign S_AXI_AWREADY_O = core_ff.awready;
	assign S_AXI_WREADY_O  = core_ff.wready;
	assign S_AXI_BVALID_O  = core_ff.bvalid;
	assign S_AXI_BRESP_O   = AXI_RESP_OKAY;
	assign S_AXI_ARREADY_O = core_ff.arready;
	assign S_AXI_RVALID_O  = core_ff.rvalid;
	assign S_AXI_RDATA_O   = {{(AXI_DW-REG_W){1'b0}}, core_ff.rdata};
	assign S_AXI_RRESP_O   = AXI_RESP_OKAY;
	assign PC_O            = core_ff.pc;
	assign DMEM_ADDR_O     = core_ff.dm_addr;
	assign DMEM_WE_O       = core_ff.dm_we;
	assign DMEM_RE_O       = core_ff.dm_re;
	assign DMEM_WDATA_O    = core_ff.dm_wdata;

endmodule : ubsr_bank

/* File: tb/ubsr_bank_chk_sva.sv */
/*
 * Checker for the upper register bank: bus answers, counter, resets and
 * indirect memory strobes, seen at the top ports only.
 * Assumes it is bound to ubsr_bank with the variant parameters handed on.
 */
module ubsr_bank_chk
	import ubsr_pkg::*;
#(
	parameter bit HAS_FOURTH_FIFTH_PORTS = 1'b1,
	parameter bit HAS_BROWNOUT_DETECT    = 1'b1
) (
	input wire logic              CLOCK_I,
	input wire logic              SRST_I,
	input wire logic              CE_I,
	input wire logic              WARM_RST_I,
	input wire logic              PC_STEP_I,
	input wire logic              S_AXI_AWVALID_I,
	input wire logic              S_AXI_WVALID_I,
	input wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
	input wire logic              S_AXI_ARVALID_I,
	input wire logic              S_AXI_AWREADY_O,
	input wire logic              S_AXI_BVALID_O,
	input wire logic [1:0]        S_AXI_BRESP_O,
	input wire logic              S_AXI_ARREADY_O,
	input wire logic              S_AXI_RVALID_O,
	input wire logic [AXI_DW-1:0] S_AXI_RDATA_O,
	input wire logic [1:0]        S_AXI_RRESP_O,
	input wire logic [PC_W-1:0]   PC_O,
	input wire logic              DMEM_WE_O,
	input wire logic              DMEM_RE_O
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [AXI_AW-1:0] rd_addr_ff;
	logic [7:0]        rd_idx;
	logic              rd_hole;

	// Address of the read under way, so its data can be judged
	always_ff @(posedge CLOCK_I) begin
		if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
			rd_addr_ff <= S_AXI_ARADDR_I;
	end
	assign rd_idx  = rd_addr_ff[9:2];
	assign rd_hole = (rd_addr_ff[11:10] != 2'h0) ||
		(rd_idx inside {8'h8F, 8'h90, 8'h91, 8'h95, 8'h96, 8'h97}) ||
		(rd_idx inside {[8'h9A:8'h9E]});

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SRST_I);

	// Read data and responses
	AST_RD_UPPER_ZERO: assert property (S_AXI_RVALID_O |->
		S_AXI_RDATA_O[31:8] == 24'h0) else $error("read upper bits set");
	AST_RD_HOLE_ZERO: assert property (S_AXI_RVALID_O && rd_hole |->
		S_AXI_RDATA_O == 32'h0) else $error("empty place read nonzero");
	AST_RESP_OKAY: assert property (S_AXI_BVALID_O || S_AXI_RVALID_O |->
		S_AXI_BRESP_O == 2'h0 && S_AXI_RRESP_O == 2'h0)
		else $error("response not okay");
	AST_ABSENT_PORTS: assert property (!HAS_FOURTH_FIFTH_PORTS &&
		S_AXI_RVALID_O && rd_addr_ff[11:10] == 2'h0 &&
		rd_idx inside {8'h88, 8'h89} |-> S_AXI_RDATA_O == 32'h0)
		else $error("absent port register nonzero");
	AST_NO_BROWNOUT: assert property (!HAS_BROWNOUT_DETECT &&
		S_AXI_RVALID_O && rd_addr_ff == 12'h238 |-> !S_AXI_RDATA_O[0])
		else $error("brownout bit set without detection");
	AST_WR_ANSWER: assert property (S_AXI_AWREADY_O && S_AXI_AWVALID_I &&
		S_AXI_WVALID_I |=> S_AXI_BVALID_O) else $error("write not answered");
	AST_RD_ANSWER: assert property (S_AXI_ARREADY_O && S_AXI_ARVALID_I |=>
		S_AXI_RVALID_O || DMEM_RE_O) else $error("read not answered");

	// Counter, resets and memory strobes
	AST_PC_STEP: assert property (PC_STEP_I && CE_I && !WARM_RST_I |=>
		PC_O == $past(PC_O) + 13'h1 || $rose(S_AXI_BVALID_O))
		else $error("counter did not step");
	AST_WARM_PC: assert property (WARM_RST_I && CE_I |=> PC_O == 13'h0)
		else $error("counter kept over warm reset");
	AST_SRST_OUTS: assert property (disable iff (1'b0) SRST_I && CE_I |=>
		PC_O == 13'h0 && !S_AXI_BVALID_O && !S_AXI_RVALID_O &&
		!DMEM_WE_O && !DMEM_RE_O) else $error("outputs live in reset");
	AST_DMEM_WE_WITH_B: assert property (DMEM_WE_O |->
		$rose(S_AXI_BVALID_O) ##1 !DMEM_WE_O) else $error("stray mem write");
	AST_DMEM_RE_ANSWER: assert property (DMEM_RE_O |-> ##2 S_AXI_RVALID_O)
		else $error("indirect read not answered");

	COV_MEM_WRITE: cover property (DMEM_WE_O);
	COV_MEM_READ: cover property (DMEM_RE_O ##2 S_AXI_RVALID_O);
	COV_WARM: cover property (WARM_RST_I ##1 !WARM_RST_I);
endmodule : ubsr_bank_chk

bind ubsr_bank ubsr_bank_chk #(
	.HAS_FOURTH_FIFTH_PORTS(HAS_FOURTH_FIFTH_PORTS),
	.HAS_BROWNOUT_DETECT   (HAS_BROWNOUT_DETECT)
) u_chk (.CLOCK_I, .SRST_I, .CE_I, .WARM_RST_I, .PC_STEP_I, .S_AXI_AWVALID_I,
	.S_AXI_WVALID_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_AWREADY_O,
	.S_AXI_BVALID_O, .S_AXI_BRESP_O, .S_AXI_ARREADY_O, .S_AXI_RVALID_O,
	.S_AXI_RDATA_O, .S_AXI_RRESP_O, .PC_O, .DMEM_WE_O, .DMEM_RE_O);

/* File: tb/ubsr_bank_bench.sv */
/*
 * Self-checking bench for ubsr_bank, variant without fourth/fifth ports
 * and brownout detection; drives AXI4-Lite and the core inputs.
 * Assumes the checker is bound from its own file; memory is a stub.
 */
module ubsr_bank_bench
	import ubsr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, srst, brown, warm, wdt, step;
	logic [5:0]  ssp;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [12:0] pc;
	logic [8:0]  maddr, we_addr;
	logic [7:0]  mem_q, mwdata, we_data;
	logic        mwe, mre;
	logic        ce, tx_idle;
	logic [3:0]  strb;
	int          n_fail = 0, compares = 0, we_cnt = 0;

	// Reset values of the plain and core registers after power-up
	localparam logic [15:0][7:0] RIDX = {8'h81, 8'h85, 8'h86, 8'h87, 8'h8C,
		8'h8D, 8'h92, 8'h93, 8'h99, 8'h9F, 8'h83, 8'h8A, 8'h8B, 8'h84,
		8'h98, 8'h94};
	localparam logic [15:0][7:0] REXP = {8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h00,
		8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00,
		8'h02, 8'h00};

	ubsr_bank #(.HAS_FOURTH_FIFTH_PORTS(1'b0), .HAS_BROWNOUT_DETECT(1'b0))
	u_dut (.CLOCK_I(clk), .SRST_I(srst), .CE_I(ce), .BROWNOUT_I(brown),
		.WARM_RST_I(warm), .WARM_WDT_I(wdt), .PC_STEP_I(step),
		.SLAVE_FLAGS_I(2'h0), .SLAVE_OVF_I(1'b0), .SSP_STATE_I(ssp),
		.TX_IDLE_I(tx_idle), .DMEM_RDATA_I(mem_q), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(strb), .S_AXI_WVALID_I(wvalid),
		.S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
		.S_AXI_ARVALID_I(arvalid), .S_AXI_RREADY_I(rready),
		.S_AXI_AWREADY_O(awready), .S_AXI_WREADY_O(wready),
		.S_AXI_BVALID_O(bvalid), .S_AXI_BRESP_O(), .S_AXI_ARREADY_O(arready),
		.S_AXI_RVALID_O(rvalid), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(),
		.PC_O(pc), .DMEM_ADDR_O(maddr), .DMEM_WE_O(mwe), .DMEM_RE_O(mre),
		.DMEM_WDATA_O(mwdata));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Memory stub: data tied to address, garbage when not read
	always @(posedge clk) begin
		mem_q <= mre ? (8'hC3 ^ maddr[7:0]) : ~mem_q;
		if (mwe) begin
			we_cnt  <= we_cnt + 1;
			we_addr <= maddr;
			we_data <= mwdata;
		end
	end

	function automatic logic [11:0] ba(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction : ba

	task chk(input string what, input logic [31:0] exp, got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Bus cycles; each starts one edge later so no signal is set twice
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask : wr

	task rchk(input string what, input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
		chk(what, {24'h0, e}, rdata);
	endtask : rchk

	task do_reset(input logic bo);
		@(posedge clk);
		srst <= 1'b1;
		brown <= bo;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		brown <= 1'b0;
	endtask : do_reset

	task warm_pulse(input logic w);
		@(posedge clk);
		warm <= 1'b1;
		wdt <= w;
		@(posedge clk);
		warm <= 1'b0;
		wdt <= 1'b0;
		@(posedge clk);
	endtask : warm_pulse

	task steps(input int n);
		@(posedge clk);
		step <= 1'b1;
		repeat (n) @(posedge clk);
		step <= 1'b0;
		@(posedge clk);
	endtask : steps

	task t_reset;
		for (int i = 0; i < 16; i++)
			rchk("reset value", ba(RIDX[i]), REXP[i]);
		rchk("absent port", ba(8'h88), 8'h00);
		rchk("absent port", ba(8'h89), 8'h00);
		rchk("reset cause", ba(8'h8E), 8'h00);
	endtask : t_reset

	task t_holes;
		wr(ba(8'h9F), 8'hFF);
		rchk("unused bits", ba(8'h9F), 8'h07);
		wr(ba(8'h8D), 8'hFF);
		rchk("unused bits", ba(8'h8D), 8'h01);
		wr(ba(8'h90), 8'h5A);
		rchk("empty place", ba(8'h90), 8'h00);
		wr(12'h400 | ba(8'h81), 8'h00);
		rchk("far address", ba(8'h81), 8'hFF);
		wr(ba(8'h88), 8'h5A);
		rchk("absent port", ba(8'h88), 8'h00);
		ssp <= 6'h2A;
		wr(ba(8'h94), 8'hFF);
		rchk("serial state", ba(8'h94), 8'h2A);
		wr(ba(8'h8C), 8'h7F);
		rchk("irq enables", ba(8'h8C), 8'h7F);
		// Byte lane 0 off: the write is answered but must not land
		strb <= 4'hE;
		wr(ba(8'h8C), 8'h00);
		rchk("strobe off", ba(8'h8C), 8'h7F);
		strb <= 4'hF;
		// Unused bit stays zero, idle bit follows its live source
		tx_idle <= 1'b0;
		wr(ba(8'h98), 8'hFF);
		rchk("tx control", ba(8'h98), 8'hF5);
	endtask : t_holes

	task t_mirror;
		wr(ba(8'h04), 8'h55);
		rchk("mirror", ba(8'h84), 8'h55);
		wr(ba(8'h8B), 8'h81);
		rchk("mirror", ba(8'h0B), 8'h81);
		wr(ba(8'h03), 8'h07);
		rchk("mirror", ba(8'h83), 8'h1F);
		wr(ba(8'h8A), 8'h15);
		rchk("mirror", ba(8'h0A), 8'h15);
	endtask : t_mirror

	// Counter low byte loads with the latch; steps never reread it
	task t_counter;
		wr(ba(8'h02), 8'h34);
		chk("counter", 32'h1534, {19'h0, pc});
		steps(3);
		chk("counter", 32'h1537, {19'h0, pc});
		wr(ba(8'h82), 8'hFF);
		steps(1);
		chk("counter", 32'h1600, {19'h0, pc});
		rchk("low byte", ba(8'h82), 8'h00);
		rchk("latch", ba(8'h8A), 8'h15);
	endtask : t_counter

	task t_indirect;
		wr(ba(8'h80), 8'hAA);
		// Stub books the strobe one edge later
		@(posedge clk);
		chk("mem writes", 32'h1, we_cnt);
		chk("mem addr", 32'h055, {23'h0, we_addr});
		chk("mem data", 32'hAA, {24'h0, we_data});
		rchk("indirect", ba(8'h00), 8'h96);
		wr(ba(8'h84), 8'h3C);
		rchk("indirect", ba(8'h80), 8'hFF);
	endtask : t_indirect

	task t_warm;
		wr(ba(8'h81), 8'h00);
		// Enable low: warm reset and counter steps must both be ignored
		ce <= 1'b0;
		warm <= 1'b1;
		step <= 1'b1;
		repeat (2) @(posedge clk);
		ce <= 1'b1;
		warm <= 1'b0;
		step <= 1'b0;
		@(posedge clk);
		chk("frozen counter", 32'h1600, {19'h0, pc});
		rchk("frozen", ba(8'h81), 8'h00);
		warm_pulse(1'b1);
		chk("counter", 32'h0, {19'h0, pc});
		rchk("warm", ba(8'h81), 8'hFF);
		rchk("warm", ba(8'h83), 8'h0F);
		rchk("warm", ba(8'h84), 8'h3C);
		rchk("warm", ba(8'h8B), 8'h01);
		rchk("warm", ba(8'h8A), 8'h00);
		warm_pulse(1'b0);
		rchk("warm", ba(8'h83), 8'h1F);
		do_reset(1'b1);
		rchk("reset cause", ba(8'h8E), 8'h02);
		rchk("power", ba(8'h83), 8'h18);
		rchk("power", ba(8'h84), 8'h00);
	endtask : t_warm

	task report_and_stop;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial begin
		{srst, brown, warm, wdt, step, awvalid, wvalid, bready} = '0;
		{arvalid, rready, awaddr, araddr, wdata, ssp} = '0;
		{ce, tx_idle, strb} = 6'h3F;
		do_reset(1'b0);
		t_reset;
		t_holes;
		t_mirror;
		t_counter;
		t_indirect;
		t_warm;
		report_and_stop;
	end

	// Whole run is a few hundred cycles; a hang ends the run here
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		report_and_stop;
	end
endmodule : ubsr_bank_bench
